// ==== pkg/acc_pkg.sv ====
/*
 * acc_pkg: register offsets, bit positions, reset values, select codes and
 * timing constants of the comparator control block.
 * Assumes a plain register port, a single 125 MHz core clock and an
 * active-high asynchronous reset.
 */
package acc_pkg;
   localparam int NUM_CMP = 2;
   localparam logic [3:0] CTRL_A1_OFS = 4'h0;
   localparam logic [3:0] CTRL_B1_OFS = 4'h1;
   localparam logic [3:0] CTRL_A2_OFS = 4'h2;
   localparam logic [3:0] CTRL_B2_OFS = 4'h3;
   localparam logic [3:0] SHARED_OFS = 4'h4;
   localparam logic [3:0] FLAG_OFS = 4'h5;
   localparam logic [3:0] ANALOG_SELECT_REG_OFS = 4'h6;
   localparam logic [3:0] PORT_OFS = 4'h7;
   // control_reg_a bits
   localparam int A_ON = 7;
   localparam int A_OUT = 6;
   localparam int A_OE = 5;
   localparam int A_POL = 4;
   localparam int A_SP = 2;
   localparam int A_HYS = 1;
   localparam int A_SYNC = 0;
   localparam logic [7:0] CTRL_A_RST = 8'h04;
   localparam logic [7:0] CTRL_A_WMASK = 8'hb7;
   // control_reg_b bits
   localparam int B_INTP = 7;
   localparam int B_INTN = 6;
   localparam int B_PCH_LO = 3;
   localparam int B_NCH_LO = 0;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
   localparam logic [7:0] ANALOG_SELECT_REG_RST = 8'hff;
   // plus select codes
   localparam logic [1:0] PSEL_PIN = 2'h0;
   localparam logic [1:0] PSEL_DAC = 2'h1;
   localparam logic [1:0] PSEL_FVR = 2'h2;
   localparam logic [1:0] PSEL_GND = 2'h3;
   // minus select codes
   localparam logic [2:0] NSEL_IN0 = 3'h0;
   localparam logic [2:0] NSEL_IN1 = 3'h1;
   localparam logic [2:0] NSEL_IN2 = 3'h2;
   localparam logic [2:0] NSEL_IN3 = 3'h3;
   localparam logic [2:0] NSEL_AGND = 3'h4;
   localparam logic [2:0] NSEL_FVR2 = 3'h5;
   // instruction cycle: 125 ns at 8 ns core period, rounded down
   localparam int INSTR_NS = 125;
   localparam int CLK_NS = 8;
   localparam int INSTR_CYC = (INSTR_NS / CLK_NS < 1) ? 1 : INSTR_NS / CLK_NS;
endpackage : acc_pkg

// ==== verilog/acc_cmp_unit.sv ====
/*
 * acc_cmp_unit: one comparator's digital path: input routing, polarity,
 * per-cycle latch, timer sync capture, edge detection.
 * Assumes the analog comparison arrives as a level on raw_i.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic tclk_fall_i,
   input wire logic raw_i,
   input wire logic [7:0] ctrl_a_i,
   input wire logic [7:0] ctrl_b_i,
   output logic [1:0] psel_o,
   output logic [2:0] nsel_o,
   output logic inputs_on_o,
   output logic result_o,
   output logic pin_o,
   output logic gate_o,
   output logic rise_o,
   output logic fall_o
);
   logic on, pol;
   logic res_q, prev_q, sync_q;
   logic [2:0] nraw;
   assign on = ctrl_a_i[acc_pkg::A_ON];
   assign pol = ctrl_a_i[acc_pkg::A_POL];
   assign nraw = ctrl_b_i[acc_pkg::B_NCH_LO +: 3];
   // ---------------------------------------------
   // input routing
   // ---------------------------------------------
   assign inputs_on_o = on;
   assign psel_o = on ? ctrl_b_i[acc_pkg::B_PCH_LO +: 2] : acc_pkg::PSEL_GND;
   assign nsel_o = (!on || nraw > acc_pkg::NSEL_FVR2) ? acc_pkg::NSEL_AGND : nraw;
   // ---------------------------------------------
   // result and edges
   // ---------------------------------------------
   // disabled comparator reads the pol bit, so toggling on or pol can still make an edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         res_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (tick_i) begin
         res_q <= (on & raw_i) ^ pol;
         prev_q <= res_q;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_q <= 1'b0;
      end else if (tclk_fall_i) begin
         sync_q <= res_q;
      end
   end
   assign result_o = res_q;
   assign pin_o = (on & raw_i) ^ pol;
   assign gate_o = ctrl_a_i[acc_pkg::A_SYNC] ? sync_q : res_q;
   assign rise_o = tick_i & res_q & ~prev_q & ctrl_b_i[acc_pkg::B_INTP];
   assign fall_o = tick_i & ~res_q & prev_q & ctrl_b_i[acc_pkg::B_INTN];
endmodule : acc_cmp_unit
`default_nettype wire

// ==== verilog/acc_top.sv ====
/*
 * acc_top: control registers, result mirror, pin override, change flags
 * and port read masking for two comparators.
 * Assumes a plain register port and an external gate timer that supplies
 * a one-cycle pulse at each falling edge of its (prescaled) clock.
 */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acc_top (
   input wire logic CORE_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic [1:0] CMP_RAW_I,
   input wire logic [1:0] TCLK_FALL_I,
   input wire logic [7:0] PORT_PIN_I,
   input wire logic [7:0] PORT_LATCH_I,
   output logic [1:0] PIN_OUT_O,
   output logic [1:0] GATE_SRC_O,
   output logic [1:0] UNIT_ON_O,
   output logic [1:0] SPEED_SELECT_O,
   output logic [1:0] HYSTERESIS_ON_O,
   output logic [3:0] PLUS_SEL_O,
   output logic [5:0] MINUS_SEL_O,
   output logic [1:0] CHANGE_FLAG_O
);
   logic [7:0] ctrl_a_q [2];
   logic [7:0] ctrl_b_q [2];
   logic [7:0] analog_select_reg_q;
   logic [1:0] flag_q;
   logic [1:0] res, pin, gate, rise, fall, inon;
   logic [1:0] psel [2];
   logic [2:0] nsel [2];
   logic [3:0] div_q;
   logic tick;
   // ---------------------------------------------
   // instruction cycle enable
   // ---------------------------------------------
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         div_q <= 4'h0;
      end else if (div_q == 4'(acc_pkg::INSTR_CYC - 1)) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end
   assign tick = (div_q == 4'(acc_pkg::INSTR_CYC - 1));
   // ---------------------------------------------
   // comparators
   // ---------------------------------------------
   for (genvar i = 0; i < acc_pkg::NUM_CMP; i++) begin : g_cmp
      acc_cmp_unit u_cmp (
         .clk_i(CORE_CLK_I),
         .rst_i(SYS_RST_I),
         .tick_i(tick),
         .tclk_fall_i(TCLK_FALL_I[i]),
         .raw_i(CMP_RAW_I[i]),
         .ctrl_a_i(ctrl_a_q[i]),
         .ctrl_b_i(ctrl_b_q[i]),
         .psel_o(psel[i]),
         .nsel_o(nsel[i]),
         .inputs_on_o(inon[i]),
         .result_o(res[i]),
         .pin_o(pin[i]),
         .gate_o(gate[i]),
         .rise_o(rise[i]),
         .fall_o(fall[i])
      );
   end
   // ---------------------------------------------
   // control registers
   // ---------------------------------------------
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ctrl_a_q[0] <= acc_pkg::CTRL_A_RST;
         ctrl_a_q[1] <= acc_pkg::CTRL_A_RST;
         ctrl_b_q[0] <= acc_pkg::CTRL_B_RST;
         ctrl_b_q[1] <= acc_pkg::CTRL_B_RST;
      end else if (WR_I) begin
         unique case (ADDR_I)
            acc_pkg::CTRL_A1_OFS: ctrl_a_q[0] <= WDATA_I & acc_pkg::CTRL_A_WMASK;
            acc_pkg::CTRL_A2_OFS: ctrl_a_q[1] <= WDATA_I & acc_pkg::CTRL_A_WMASK;
            acc_pkg::CTRL_B1_OFS: ctrl_b_q[0] <= WDATA_I & acc_pkg::CTRL_B_WMASK;
            acc_pkg::CTRL_B2_OFS: ctrl_b_q[1] <= WDATA_I & acc_pkg::CTRL_B_WMASK;
            default: ;
         endcase
      end
   end
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         analog_select_reg_q <= acc_pkg::ANALOG_SELECT_REG_RST;
      end else if (WR_I && ADDR_I == acc_pkg::ANALOG_SELECT_REG_OFS) begin
         analog_select_reg_q <= WDATA_I;
      end
   end
   // ---------------------------------------------
   // change flags
   // ---------------------------------------------
   // set beats a clear in the same cycle, so no edge is lost
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         flag_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (rise[i] | fall[i]) begin
               flag_q[i] <= 1'b1;
            end else if (WR_I && ADDR_I == acc_pkg::FLAG_OFS && !WDATA_I[i]) begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   end
   // ---------------------------------------------
   // read port
   // ---------------------------------------------
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         RDATA_O <= 8'h00;
      end else if (RD_I) begin
         unique case (ADDR_I)
            acc_pkg::CTRL_A1_OFS: RDATA_O <= {ctrl_a_q[0][7], res[0], ctrl_a_q[0][5:0]};
            acc_pkg::CTRL_A2_OFS: RDATA_O <= {ctrl_a_q[1][7], res[1], ctrl_a_q[1][5:0]};
            acc_pkg::CTRL_B1_OFS: RDATA_O <= ctrl_b_q[0];
            acc_pkg::CTRL_B2_OFS: RDATA_O <= ctrl_b_q[1];
            acc_pkg::SHARED_OFS: RDATA_O <= {6'h00, res};
            acc_pkg::FLAG_OFS: RDATA_O <= {6'h00, flag_q};
            acc_pkg::ANALOG_SELECT_REG_OFS: RDATA_O <= analog_select_reg_q;
            acc_pkg::PORT_OFS: RDATA_O <= PORT_PIN_I & ~analog_select_reg_q;
            default: RDATA_O <= 8'h00;
         endcase
      end else begin
         RDATA_O <= 8'h00;
      end
   end
   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   // pin path is the unlatched result; registering only to meet the flop-output style
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         PIN_OUT_O <= 2'h0;
         GATE_SRC_O <= 2'h0;
         UNIT_ON_O <= 2'h0;
         SPEED_SELECT_O <= 2'h3;
         HYSTERESIS_ON_O <= 2'h0;
         PLUS_SEL_O <= {acc_pkg::PSEL_GND, acc_pkg::PSEL_GND};
         MINUS_SEL_O <= {acc_pkg::NSEL_AGND, acc_pkg::NSEL_AGND};
         CHANGE_FLAG_O <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            // override is independent of unit_on; pin_direction is software's job
            PIN_OUT_O[i] <= ctrl_a_q[i][acc_pkg::A_OE] ? pin[i] : PORT_LATCH_I[i];
            GATE_SRC_O[i] <= gate[i];
            UNIT_ON_O[i] <= inon[i];
            SPEED_SELECT_O[i] <= ctrl_a_q[i][acc_pkg::A_SP];
            HYSTERESIS_ON_O[i] <= ctrl_a_q[i][acc_pkg::A_HYS];
         end
         PLUS_SEL_O <= {psel[1], psel[0]};
         MINUS_SEL_O <= {nsel[1], nsel[0]};
         CHANGE_FLAG_O <= flag_q;
      end
   end
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   property p_flag_set;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I) (rise[0] | fall[0]) |=> flag_q[0];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");
   property p_flag_keep;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
         ((rise[1] | fall[1]) && WR_I && ADDR_I == acc_pkg::FLAG_OFS && !WDATA_I[1]) |=> flag_q[1];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("clear beat an edge");
   property p_mirror;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
         (RD_I && ADDR_I == acc_pkg::SHARED_OFS) |=> RDATA_O[1:0] == $past(res);
   endproperty
   a_mirror: assert property (p_mirror) else $error("shared result mismatch");
   property p_port_mask;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
         (RD_I && ADDR_I == acc_pkg::PORT_OFS && analog_select_reg_q[0]) |=> !RDATA_O[0];
   endproperty
   a_port_mask: assert property (p_port_mask) else $error("analog pin read nonzero");
   property p_override;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
         ctrl_a_q[0][acc_pkg::A_OE] |=> PIN_OUT_O[0] == $past(pin[0]);
   endproperty
   a_override: assert property (p_override) else $error("pin override wrong");
   property p_off_inputs;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
         !ctrl_a_q[0][acc_pkg::A_ON] |-> psel[0] == acc_pkg::PSEL_GND && nsel[0] == acc_pkg::NSEL_AGND;
   endproperty
   a_off_inputs: assert property (p_off_inputs) else $error("inputs not cut off");
   // helper: cycles since the last tick, so the period check needs no long repetition
   logic [3:0] gap_q;
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         gap_q <= 4'h0;
      end else if (tick) begin
         gap_q <= 4'h0;
      end else begin
         gap_q <= gap_q + 4'h1;
      end
   end
   property p_tick_rate;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I) tick == (gap_q == 4'(acc_pkg::INSTR_CYC - 1));
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("instruction tick period wrong");
   property p_result;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
         tick |=> res[1] == ($past(ctrl_a_q[1][acc_pkg::A_ON] & CMP_RAW_I[1]) ^ $past(ctrl_a_q[1][acc_pkg::A_POL]));
   endproperty
   a_result: assert property (p_result) else $error("result polarity wrong");
   property p_speed;
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
         1'b1 |=> SPEED_SELECT_O[0] == $past(ctrl_a_q[0][acc_pkg::A_SP]);
   endproperty
   a_speed: assert property (p_speed) else $error("speed select not passed");
endmodule : acc_top
`default_nettype wire

// ==== tb/acc_gate_timer.sv ====
/*
 * acc_gate_timer: gate timer stand-in giving one-cycle pulses at each
 * falling edge of its prescaled clock, one output per comparator.
 * Assumes the bench core clock; pulses only while run_i is high.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_gate_timer #(
   parameter int PRESC = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] run_i,
   output logic [1:0] fall_o
);
   // ----------------------------------------
   // prescaled fall pulses
   // ----------------------------------------
   logic [7:0] cnt_q;
   // stopped timer gives no pulses, so a held capture can be seen
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 8'h00;
         fall_o <= 2'h0;
      end else begin
         fall_o <= run_i & {2{cnt_q == 8'(PRESC - 1)}};
         cnt_q <= (cnt_q == 8'(PRESC - 1)) ? 8'h00 : cnt_q + 8'h01;
      end
   end
endmodule : acc_gate_timer
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * tb_top: self-checking bench for acc_top with a gate timer stand-in.
 * Assumes the register map and instruction-tick result update of the design.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] raw = 2'h0;
   logic [1:0] run = 2'h0;
   logic [7:0] pins = 8'h00;
   logic [7:0] latch = 8'h00;
   logic [7:0] rdata;
   logic [1:0] tfall, pin_out, gate, on_o, sp_o, hys_o, flag;
   logic [3:0] psel;
   logic [5:0] nsel;
   logic [7:0] d, a;
   logic on, pol, r, o, sp, hy, e;
   logic [1:0] p;
   int fails = 0;
   int comparisons = 0;
   always #4 clk = ~clk;
   acc_top acc_top_i (.CORE_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .CMP_RAW_I(raw), .TCLK_FALL_I(tfall), .PORT_PIN_I(pins),
      .PORT_LATCH_I(latch), .PIN_OUT_O(pin_out), .GATE_SRC_O(gate), .UNIT_ON_O(on_o),
      .SPEED_SELECT_O(sp_o), .HYSTERESIS_ON_O(hys_o), .PLUS_SEL_O(psel), .MINUS_SEL_O(nsel),
      .CHANGE_FLAG_O(flag));
   acc_gate_timer acc_gate_timer_i (.clk_i(clk), .rst_i(rst), .run_i(run), .fall_o(tfall));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic print_verdict();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [3:0] ad, input logic [7:0] v);
      @(posedge clk);
      addr <= ad;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] ad, output logic [7:0] v);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg
   // bounded wait on gate (f=0) or change flag (f=1); a timeout ends the run
   task automatic wait_sig(input int f, input int u, input logic ex);
      int n;
      tick(2);
      for (n = 0; n < 200 && (f ? flag[u] : gate[u]) !== ex; n++) tick(1);
      chk({7'h0, f ? flag[u] : gate[u]}, {7'h0, ex});
      if (n == 200) print_verdict();
   endtask : wait_sig
   // back-to-back flag clears across an edge: the flag must still show up once
   task automatic clr_burst(input int u);
      logic seen;
      seen = 1'b0;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         addr <= acc_pkg::FLAG_OFS;
         wdata <= 8'h00;
         wr <= 1'b1;
         #1;
         seen = seen | flag[u];
      end
      @(posedge clk);
      wr <= 1'b0;
      chk({7'h0, seen}, 8'h01);
   endtask : clr_burst
   function automatic logic [7:0] fa(logic n, logic oe, logic pl, logic s, logic h, logic sy);
      return {n, 1'b0, oe, pl, 1'b0, s, h, sy};
   endfunction : fa
   function automatic logic [3:0] oa(int u);
      return u ? acc_pkg::CTRL_A2_OFS : acc_pkg::CTRL_A1_OFS;
   endfunction : oa
   function automatic logic [3:0] ob(int u);
      return u ? acc_pkg::CTRL_B2_OFS : acc_pkg::CTRL_B1_OFS;
   endfunction : ob
   // unused minus codes fall back to analog ground, off unit grounds all
   function automatic logic [2:0] exp_n(logic n_on, logic [2:0] c);
      return (n_on && c < 3'h6) ? c : acc_pkg::NSEL_AGND;
   endfunction : exp_n
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      print_verdict();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h99697491));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      chk({2'h0, sp_o, hys_o, on_o}, 8'h30);
      chk({2'h0, nsel}, 8'h24);
      chk({4'h0, psel}, 8'h0f);
      for (int u = 0; u < 2; u++) begin
         rd_reg(oa(u), d);
         chk(d, acc_pkg::CTRL_A_RST);
      end
      wr_reg(4'h9, 8'hff);
      rd_reg(4'h9, d);
      chk(d, 8'h00);
      for (int i = 0; i < 4; i++) begin
         a = 8'($urandom);
         @(posedge clk);
         pins <= 8'($urandom);
         wr_reg(acc_pkg::ANALOG_SELECT_REG_OFS, a);
         rd_reg(acc_pkg::PORT_OFS, d);
         chk(d, pins & ~a);
      end
      for (int u = 0; u < 2; u++) begin
         for (int i = 0; i < 8; i++) begin
            {on, pol, r} = 3'(i);
            {o, sp, hy} = 3'($urandom);
            e = (on & r) ^ pol;
            @(posedge clk);
            raw[u] <= r;
            latch <= 8'($urandom);
            wr_reg(oa(u), fa(on, o, pol, sp, hy, 1'b0));
            wait_sig(0, u, e);
            chk({6'h0, on_o[u], pin_out[u]}, {6'h0, on, o ? e : latch[u]});
            chk({6'h0, sp_o[u], hys_o[u]}, {6'h0, sp, hy});
            rd_reg(acc_pkg::SHARED_OFS, d);
            chk({7'h0, d[u]}, {7'h0, e});
            rd_reg(oa(u), d);
            chk(d, fa(on, o, pol, sp, hy, 1'b0) | {1'b0, e, 6'h0});
         end
         for (int n = 0; n < 8; n++) begin
            {on, p} = 3'($urandom);
            wr_reg(ob(u), {3'h0, p, 3'(n)});
            wr_reg(oa(u), fa(on, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
            tick(2);
            chk({6'h0, psel[2*u+:2]}, {6'h0, on ? p : acc_pkg::PSEL_GND});
            chk({5'h0, nsel[3*u+:3]}, {5'h0, exp_n(on, 3'(n))});
            rd_reg(ob(u), d);
            chk(d, {3'h0, p, 3'(n)});
         end
         // edge flags, comparator left off so only polarity and enable move it
         @(posedge clk);
         raw[u] <= 1'b0;
         wr_reg(oa(u), fa(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
         wait_sig(0, u, 1'b0);
         wr_reg(ob(u), 8'h80);
         wr_reg(acc_pkg::FLAG_OFS, 8'h00);
         tick(2);
         chk({7'h0, flag[u]}, 8'h00);
         wr_reg(oa(u), fa(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
         wait_sig(1, u, 1'b1);
         wr_reg(acc_pkg::FLAG_OFS, 8'h00);
         tick(2);
         chk({7'h0, flag[u]}, 8'h00);
         wr_reg(oa(u), fa(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
         wait_sig(0, u, 1'b0);
         tick(20);
         chk({7'h0, flag[u]}, 8'h00);
         wr_reg(ob(u), 8'h40);
         wr_reg(oa(u), fa(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
         wait_sig(0, u, 1'b1);
         tick(20);
         chk({7'h0, flag[u]}, 8'h00);
         @(posedge clk);
         raw[u] <= 1'b1;
         wr_reg(oa(u), fa(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
         clr_burst(u);
         wr_reg(acc_pkg::FLAG_OFS, 8'h00);
         // timer sync: gate holds between timer fall pulses
         wr_reg(oa(u), fa(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
         @(posedge clk);
         raw[u] <= 1'b0;
         run <= 2'h3;
         wait_sig(0, u, 1'b0);
         @(posedge clk);
         run <= 2'h0;
         raw[u] <= 1'b1;
         tick(40);
         chk({7'h0, gate[u]}, 8'h00);
         rd_reg(acc_pkg::SHARED_OFS, d);
         chk({7'h0, d[u]}, 8'h01);
         @(posedge clk);
         run <= 2'h3;
         wait_sig(0, u, 1'b1);
      end
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
